// ==== verification/i2c_status_and_clock_timing_tb.sv ====
// Self-checking bench for the status flags, SCL timing and register slave
`timescale 1ns/1ps
`default_nettype none
module i2c_status_and_clock_timing_tb;
  import i2cst_pkg::*;
  typedef struct {
    logic [1:0] op;
    logic [7:0] a;
    logic [15:0] d;
    logic [15:0] e;
  } i2cst_row_s;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, scl_in, scl_out, scl_oe, sda_in, scl_run_i = 1'b0;
  logic [8:0] ev = 9'h000;
  logic aux_r = 1'b0;
  logic [7:0] checksum_i = 8'h00;
  logic [7:0] stretch = 8'h00;
  logic sda_low = 1'b0;
  logic role_is_master, line_busy_flag, peripheral_enable, irq;
  logic are, hts, cke;
  logic [31:0] q;
  int n_fail = 0;
  int n_tests = 0;
  // Ops: 0 read, 1 write, 2 event pulse (a = event index) then status read
  i2cst_row_s rows [$] = '{
    '{2'd0, 8'h18, 16'h0000, 16'h0000}, '{2'd0, 8'h1c, 16'h0000, 16'h0000},
    '{2'd0, 8'h20, 16'h0000, 16'h0002}, '{2'd0, 8'h24, 16'h0000, 16'h0000},
    '{2'd0, 8'h30, 16'h0000, 16'h0000}, '{2'd1, 8'h1c, 16'hffff, 16'h0000},
    '{2'd0, 8'h1c, 16'h0000, 16'hcfff}, '{2'd1, 8'h20, 16'hffff, 16'h0000},
    '{2'd0, 8'h20, 16'h0000, 16'h003f}, '{2'd1, 8'h18, 16'hffff, 16'h0000},
    '{2'd0, 8'h18, 16'h0000, 16'h0000}, '{2'd1, 8'h30, 16'hffff, 16'h0000},
    '{2'd0, 8'h30, 16'h0000, 16'h0000}, '{2'd1, 8'h24, 16'h000f, 16'h0000},
    '{2'd2, 8'h05, 16'h0000, 16'h0010}, '{2'd2, 8'h02, 16'h0000, 16'h0000},
    '{2'd2, 8'h06, 16'h0000, 16'h0020}, '{2'd2, 8'h02, 16'h0000, 16'h0000},
    '{2'd2, 8'h07, 16'h0000, 16'h0040}, '{2'd1, 8'h24, 16'h0000, 16'h0000},
    '{2'd0, 8'h18, 16'h0000, 16'h0000}, '{2'd1, 8'h24, 16'h000f, 16'h0000},
    '{2'd2, 8'h08, 16'h0001, 16'h0080}, '{2'd2, 8'h02, 16'h0000, 16'h0000},
    '{2'd2, 8'h00, 16'h0000, 16'h0001}, '{2'd2, 8'h04, 16'h0001, 16'h0005},
    '{2'd2, 8'h05, 16'h0000, 16'h0005}, '{2'd2, 8'h02, 16'h0000, 16'h0001},
    '{2'd2, 8'h04, 16'h0001, 16'h0005}, '{2'd2, 8'h01, 16'h0000, 16'h0000},
    '{2'd2, 8'h00, 16'h0000, 16'h0001}, '{2'd2, 8'h03, 16'h0000, 16'h0000},
    '{2'd2, 8'h00, 16'h0000, 16'h0001}, '{2'd1, 8'h24, 16'h0000, 16'h0000},
    '{2'd0, 8'h18, 16'h0000, 16'h0000}, '{2'd1, 8'h24, 16'h0001, 16'h0000},
    '{2'd2, 8'h06, 16'h0000, 16'h0000}, '{2'd2, 8'h07, 16'h0000, 16'h0000},
    '{2'd1, 8'h24, 16'h0005, 16'h0000}, '{2'd2, 8'h07, 16'h0000, 16'h0000},
    '{2'd1, 8'h24, 16'h000f, 16'h0000}};
  ////////////////////////////////////////////////////////////////////////////
  i2cst_top i2cst_top_i (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_in), .master_start_i(ev[0]), .stop_generated_i(ev[1]),
    .repeated_start_i(ev[2]), .arb_lost_i(ev[3]), .scl_run_i(scl_run_i),
    .addr_dir_valid_i(ev[4]), .addr_dir_tx_i(aux_r), .bcast_hit_i(ev[5]),
    .default_addr_hit_i(ev[6]), .host_header_hit_i(ev[7]),
    .own_addr_hit_i(ev[8]), .own_addr_second_i(aux_r),
    .checksum_i(checksum_i), .role_is_master(role_is_master),
    .line_busy_flag(line_busy_flag), .peripheral_enable(peripheral_enable),
    .addr_resolution_enable(are), .smbus_host_type_select(hts),
    .checksum_enable(cke), .irq(irq));
  i2cst_bus_model i2cst_bus_model_i (.sys_clk(sys_clk), .scl_oe(scl_oe),
    .sda_low(sda_low), .stretch(stretch), .scl_line(scl_in),
    .sda_line(sda_in));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d,
                    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, d};
    @(posedge sys_clk);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) chk("wb_ack", 32'h1, 32'h0);
  endtask : wb
  task automatic pulse(input logic [7:0] i, input logic aux);
    @(posedge sys_clk);
    ev[i] <= 1'b1;
    aux_r <= aux;
    @(posedge sys_clk);
    ev <= 9'h000;
  endtask : pulse
  // Low length must be exact; the gap adds the rise wait and any stretch
  task automatic scl_case(input logic [15:0] ctl, input logic [15:0] rise,
                          input int st, input int lo, input int hi);
    int n;
    int g;
    wb(1'b1, ADR_CLK_CTRL, ctl, q);
    wb(1'b1, ADR_RISE_TIME, rise, q);
    stretch <= st[7:0];
    scl_run_i <= 1'b1;
    n = 0;
    g = 0;
    while (scl_oe !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    n = 0;
    while (scl_oe === 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    while (scl_oe !== 1'b1 && g < 400) begin
      @(posedge sys_clk);
      g++;
    end
    scl_run_i <= 1'b0;
    chk("scl_low", lo, n);
    chk("scl_high", 1, (g >= hi + st && g <= hi + st + 6));
    repeat (100) @(posedge sys_clk);
  endtask : scl_case
  task automatic tally_and_finish;
    if (n_fail == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #(25 * 20000);
    n_fail++;
    tally_and_finish;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rows[k]) begin
      if (rows[k].op == 2'd2) begin
        pulse(rows[k].a, rows[k].d[0]);
        wb(1'b0, ADR_STATUS_TWO, 16'h0000, q);
      end else begin
        wb(rows[k].op[0], rows[k].a, rows[k].d, q);
      end
      if (rows[k].op != 2'd1) chk($sformatf("row %0d", k), {16'h0000, rows[k].e}, q);
    end
    checksum_i <= 8'h5a;
    wb(1'b0, ADR_STATUS_TWO, 16'h0000, q);
    chk("checksum_on", 32'h00005a00, q);
    wb(1'b1, ADR_CONTROL, 16'h0007, q);
    wb(1'b0, ADR_STATUS_TWO, 16'h0000, q);
    chk("checksum_off", 32'h00000000, q);
    // Busy, stop on the pins and the interrupt path
    wb(1'b1, ADR_CONTROL, 16'h000f, q);
    chk("ctl_pins", 32'hf, {28'h0, cke, hts, are, peripheral_enable});
    chk("scl_out", 32'h0, scl_out);
    wb(1'b0, ADR_IRQ_STATUS, 16'h0000, q);
    wb(1'b1, ADR_IRQ_MASK, 16'h0001, q);
    sda_low <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk("busy_on", 32'h1, line_busy_flag);
    chk("irq_on", 32'h1, irq);
    pulse(8'h05, 1'b0);
    wb(1'b0, ADR_IRQ_STATUS, 16'h0000, q);
    chk("irq_status", 32'h00000009, q);
    repeat (2) @(posedge sys_clk);
    chk("irq_cleared", 32'h0, irq);
    sda_low <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk("busy_off", 32'h0, line_busy_flag);
    chk("irq_masked", 32'h0, irq);
    wb(1'b0, ADR_STATUS_TWO, 16'h0000, q);
    chk("stop_clears", 32'h00005a00, q);
    wb(1'b0, ADR_IRQ_STATUS, 16'h0000, q);
    chk("irq_stop", 32'h00000002, q);
    // SCL phases in every speed mode, zero divider and a stretching slave
    pulse(8'h00, 1'b0);
    scl_case(16'h0003, 16'h0002, 0, 3, 3);
    scl_case(16'h8003, 16'h0002, 0, 6, 3);
    scl_case(16'hc001, 16'h0002, 0, 16, 9);
    scl_case(16'h0000, 16'h0002, 0, 1, 1);
    scl_case(16'h0002, 16'h003f, 8, 2, 2);
    // Reset after a clock control write, with the SCL generator idle, restores the documented values
    wb(1'b1, ADR_CLK_CTRL, 16'h8005, q);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    wb(1'b0, ADR_CLK_CTRL, 16'h0000, q);
    chk("rst_clk", 32'h00000000, q);
    wb(1'b0, ADR_RISE_TIME, 16'h0000, q);
    chk("rst_rise", 32'h00000002, q);
    wb(1'b0, ADR_STATUS_TWO, 16'h0000, q);
    chk("rst_status", 32'h00000000, q);
    tally_and_finish;
  end
endmodule : i2c_status_and_clock_timing_tb
`default_nettype wire

// ==== verification/i2cst_bus_model.sv ====
// Bus partner model: open-drain SCL and SDA with pull-ups, slave stretching
`timescale 1ns/1ps
`default_nettype none
module i2cst_bus_model (
  input wire logic sys_clk,
  input wire logic scl_oe,
  input wire logic sda_low,
  input wire logic [7:0] stretch,
  output logic scl_line,
  output logic sda_line
);
  logic oe_d_r = 1'b0;
  logic [7:0] hold_r = 8'h00;
  logic hold_now;
  ////////////////////////////////////////////////////////////////////////////
  // Stretching starts in the very cycle the design lets go, so no glitch
  // high reaches the synchroniser before the hold takes over
  always_ff @(posedge sys_clk) begin
    oe_d_r <= scl_oe;
    if (oe_d_r && !scl_oe) begin
      hold_r <= stretch;
    end else if (hold_r != 8'h00) begin
      hold_r <= hold_r - 8'h01;
    end
  end
  assign hold_now = (oe_d_r && !scl_oe && stretch != 8'h00) || hold_r != 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  // Pull-ups: a released line reads high, never the last driven value
  assign scl_line = !(scl_oe || hold_now);
  assign sda_line = !sda_low;
endmodule : i2cst_bus_model
`default_nettype wire

// ==== verilog/i2cst_pkg.sv ====
// Constants and types for the I2C status and master clock timing block
`default_nettype none
package i2cst_pkg;
  // Register byte addresses
  localparam logic [7:0] ADR_STATUS_TWO = 8'h18;
  localparam logic [7:0] ADR_CLK_CTRL = 8'h1c;
  localparam logic [7:0] ADR_RISE_TIME = 8'h20;
  localparam logic [7:0] ADR_CONTROL = 8'h24;
  localparam logic [7:0] ADR_IRQ_STATUS = 8'h28;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h2c;
  // Reset values
  localparam logic [15:0] RST_CLK_CTRL = 16'h0000;
  localparam logic [15:0] RST_RISE_TIME = 16'h0002;
  localparam logic [15:0] RST_CONTROL = 16'h0000;
  localparam logic [3:0] RST_IRQ = 4'h0;
  // Writable bits of each register
  localparam logic [15:0] MASK_CLK_CTRL = 16'hcfff;
  localparam logic [15:0] MASK_RISE_TIME = 16'h003f;
  localparam logic [15:0] MASK_CONTROL = 16'h000f;
  localparam logic [15:0] MASK_IRQ = 16'h000f;
  // Status two fields
  localparam int BIT_ROLE = 0;
  localparam int BIT_BUSY = 1;
  localparam int BIT_DIR = 2;
  localparam int BIT_BCAST = 4;
  localparam int BIT_DEFADR = 5;
  localparam int BIT_HOSTHDR = 6;
  localparam int BIT_SECOND = 7;
  localparam int CHK_LSB = 8;
  localparam int CHK_MSB = 15;
  // Clock control and rise time fields
  localparam int DIV_MSB = 11;
  localparam int DUTY_BIT = 14;
  localparam int SPEED_BIT = 15;
  localparam int RISE_MSB = 5;
  // Control fields
  localparam int CTL_ENABLE = 0;
  localparam int CTL_ARP = 1;
  localparam int CTL_HOSTSEL = 2;
  localparam int CTL_CHKEN = 3;
  // Interrupt events
  localparam int EV_BUSY_ON = 0;
  localparam int EV_BUSY_OFF = 1;
  localparam int EV_ARB = 2;
  localparam int EV_ADDR = 3;
  // Phase multipliers
  localparam logic [16:0] MUL_FAST_LOW = 17'h00002;
  localparam logic [16:0] MUL_DUTY_HIGH = 17'h00009;
  localparam logic [16:0] MUL_DUTY_LOW = 17'h00010;
  typedef enum logic [1:0] {
    SCL_IDLE = 2'b00,
    SCL_LOW = 2'b01,
    SCL_RISE = 2'b10,
    SCL_HIGH = 2'b11
  } i2cst_scl_e;
endpackage : i2cst_pkg
`default_nettype wire

// ==== verilog/i2cst_top.sv ====
// I2C status flags, master SCL timing and Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module i2cst_top
  import i2cst_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  input wire logic master_start_i,
  input wire logic stop_generated_i,
  input wire logic repeated_start_i,
  input wire logic arb_lost_i,
  input wire logic scl_run_i,
  input wire logic addr_dir_valid_i,
  input wire logic addr_dir_tx_i,
  input wire logic bcast_hit_i,
  input wire logic default_addr_hit_i,
  input wire logic host_header_hit_i,
  input wire logic own_addr_hit_i,
  input wire logic own_addr_second_i,
  input wire logic [7:0] checksum_i,
  output logic role_is_master,
  output logic line_busy_flag,
  output logic peripheral_enable,
  output logic addr_resolution_enable,
  output logic smbus_host_type_select,
  output logic checksum_enable,
  output logic irq
);

  function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] dat, input logic [3:0] sel, input logic [15:0] msk);
    logic [15:0] r;
    r = old;
    if (sel[0]) r[7:0] = dat[7:0];
    if (sel[1]) r[15:8] = dat[15:8];
    return r & msk;
  endfunction : merge16

  // Length of one SCL phase in clock cycles, never below one
  function automatic logic [16:0] phase_len(input logic [11:0] div,
      input logic fast, input logic duty, input logic high);
    logic [16:0] d;
    logic [16:0] r;
    d = {5'h00, div};
    if (!fast) r = d;
    else if (!duty) r = high ? d : 17'(d * MUL_FAST_LOW);
    else r = high ? 17'(d * MUL_DUTY_HIGH) : 17'(d * MUL_DUTY_LOW);
    return (r == 17'h00000) ? 17'h00001 : r;
  endfunction : phase_len

  logic [15:0] clk_ctrl_r;
  logic [15:0] rise_r;
  logic [15:0] ctrl_r;
  logic [3:0] irq_stat_r;
  logic [3:0] irq_mask_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic scl_meta_r, scl_s_r, sda_meta_r, sda_s_r, sda_prev_r;
  logic dir_r, bcast_r, defadr_r, host_r, second_r;
  logic [7:0] chk_r;
  i2cst_scl_e st_r;
  logic [16:0] cnt_r;
  logic [5:0] rise_cnt_r;
  logic scl_oe_r;

  logic en, stop_seen, wr_stb, rd_stb, slave_clr, run, rise_done;
  logic [16:0] lo_len, hi_len;
  logic [15:0] status_two;
  logic [3:0] ev;

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, unmapped reads zero, writes dropped

  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
  assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_r;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  always_ff @(posedge sys_clk) begin
    if (rst) ack_r <= 1'b0;
    else ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdat_r <= 32'h00000000;
    end else if (rd_stb) begin
      unique case (wb_adr_i)
        ADR_STATUS_TWO: rdat_r <= {16'h0000, status_two};
        ADR_CLK_CTRL: rdat_r <= {16'h0000, clk_ctrl_r};
        ADR_RISE_TIME: rdat_r <= {16'h0000, rise_r};
        ADR_CONTROL: rdat_r <= {16'h0000, ctrl_r};
        ADR_IRQ_STATUS: rdat_r <= {28'h0000000, irq_stat_r};
        ADR_IRQ_MASK: rdat_r <= {28'h0000000, irq_mask_r};
        default: rdat_r <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clk_ctrl_r <= RST_CLK_CTRL;
      rise_r <= RST_RISE_TIME;
      ctrl_r <= RST_CONTROL;
      irq_mask_r <= RST_IRQ;
    end else if (wr_stb) begin
      if (wb_adr_i == ADR_CLK_CTRL)
        clk_ctrl_r <= merge16(clk_ctrl_r, wb_dat_i, wb_sel_i, MASK_CLK_CTRL);
      if (wb_adr_i == ADR_RISE_TIME)
        rise_r <= merge16(rise_r, wb_dat_i, wb_sel_i, MASK_RISE_TIME);
      if (wb_adr_i == ADR_CONTROL)
        ctrl_r <= merge16(ctrl_r, wb_dat_i, wb_sel_i, MASK_CONTROL);
      if (wb_adr_i == ADR_IRQ_MASK)
        irq_mask_r <= 4'(merge16({12'h000, irq_mask_r}, wb_dat_i, wb_sel_i,
            MASK_IRQ));
    end
  end

  assign en = ctrl_r[CTL_ENABLE];
  assign peripheral_enable = en;
  assign addr_resolution_enable = ctrl_r[CTL_ARP];
  assign smbus_host_type_select = ctrl_r[CTL_HOSTSEL];
  assign checksum_enable = ctrl_r[CTL_CHKEN];

  //////////////////////////////////////////////////////////////////////////////
  // Line synchronisers and stop detection

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_meta_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_meta_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_meta_r <= scl_in;
      scl_s_r <= scl_meta_r;
      sda_meta_r <= sda_in;
      sda_s_r <= sda_meta_r;
      sda_prev_r <= sda_s_r;
    end
  end

  // Stop: SDA rises while SCL stays high
  assign stop_seen = scl_s_r & sda_s_r & ~sda_prev_r;

  //////////////////////////////////////////////////////////////////////////////
  // Status flags; a new event wins over a clear in the same cycle

  always_ff @(posedge sys_clk) begin
    if (rst) role_is_master <= 1'b0;
    else if (!en) role_is_master <= 1'b0;
    else if (master_start_i) role_is_master <= 1'b1;
    else if (stop_generated_i | arb_lost_i) role_is_master <= 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) line_busy_flag <= 1'b0;
    else if (~scl_s_r | ~sda_s_r) line_busy_flag <= 1'b1;
    else if (stop_seen) line_busy_flag <= 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) dir_r <= 1'b0;
    else if (!en) dir_r <= 1'b0;
    else if (addr_dir_valid_i) dir_r <= addr_dir_tx_i;
    else if (stop_seen | stop_generated_i | repeated_start_i | arb_lost_i)
      dir_r <= 1'b0;
  end

  // Slave address flags share one clear; disable always wins
  assign slave_clr = stop_seen | repeated_start_i;

  always_ff @(posedge sys_clk) begin
    if (rst | ~en) begin
      bcast_r <= 1'b0;
      defadr_r <= 1'b0;
      host_r <= 1'b0;
      second_r <= 1'b0;
    end else begin
      if (bcast_hit_i & ~role_is_master) bcast_r <= 1'b1;
      else if (slave_clr) bcast_r <= 1'b0;
      if (default_addr_hit_i & ~role_is_master & ctrl_r[CTL_ARP])
        defadr_r <= 1'b1;
      else if (slave_clr) defadr_r <= 1'b0;
      if (host_header_hit_i & ~role_is_master & ctrl_r[CTL_ARP]
          & ctrl_r[CTL_HOSTSEL])
        host_r <= 1'b1;
      else if (slave_clr) host_r <= 1'b0;
      if (own_addr_hit_i & ~role_is_master)
        second_r <= own_addr_second_i;
      else if (slave_clr) second_r <= 1'b0;
    end
  end

  // Checksum reads zero while checking is off
  always_ff @(posedge sys_clk) begin
    if (rst) chk_r <= 8'h00;
    else chk_r <= ctrl_r[CTL_CHKEN] ? checksum_i : 8'h00;
  end

  always_comb begin
    status_two = 16'h0000;
    status_two[BIT_ROLE] = role_is_master;
    status_two[BIT_BUSY] = line_busy_flag;
    status_two[BIT_DIR] = dir_r;
    status_two[BIT_BCAST] = bcast_r;
    status_two[BIT_DEFADR] = defadr_r;
    status_two[BIT_HOSTHDR] = host_r;
    status_two[BIT_SECOND] = second_r;
    status_two[CHK_MSB:CHK_LSB] = chk_r;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status: sticky, cleared by a read, set wins over clear

  always_comb begin
    ev = 4'h0;
    ev[EV_BUSY_ON] = ~line_busy_flag & (~scl_s_r | ~sda_s_r);
    ev[EV_BUSY_OFF] = line_busy_flag & scl_s_r & sda_s_r & stop_seen;
    ev[EV_ARB] = role_is_master & arb_lost_i & en;
    ev[EV_ADDR] = en & ~role_is_master & (bcast_hit_i | own_addr_hit_i
        | (default_addr_hit_i & ctrl_r[CTL_ARP]));
  end

  always_ff @(posedge sys_clk) begin
    if (rst) irq_stat_r <= RST_IRQ;
    else if (rd_stb && wb_adr_i == ADR_IRQ_STATUS) irq_stat_r <= ev;
    else irq_stat_r <= irq_stat_r | ev;
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  //////////////////////////////////////////////////////////////////////////////
  // SCL generator for master mode

  assign lo_len = phase_len(clk_ctrl_r[DIV_MSB:0], clk_ctrl_r[SPEED_BIT],
      clk_ctrl_r[DUTY_BIT], 1'b0);
  assign hi_len = phase_len(clk_ctrl_r[DIV_MSB:0], clk_ctrl_r[SPEED_BIT],
      clk_ctrl_r[DUTY_BIT], 1'b1);
  assign run = en & role_is_master & scl_run_i;
  // Programmed value is rise time plus one
  assign rise_done = ({1'b0, rise_cnt_r} + 7'h01)
      >= {1'b0, rise_r[RISE_MSB:0]};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= SCL_IDLE;
      cnt_r <= 17'h00000;
      rise_cnt_r <= 6'h00;
      scl_oe_r <= 1'b0;
    end else begin
      unique case (st_r)
        SCL_IDLE: begin
          if (run) begin
            st_r <= SCL_LOW;
            cnt_r <= lo_len;
            scl_oe_r <= 1'b1;
          end
        end
        SCL_LOW: begin
          if (!run) begin
            st_r <= SCL_IDLE;
            scl_oe_r <= 1'b0;
          end else if (cnt_r == 17'h00001) begin
            st_r <= SCL_RISE;
            rise_cnt_r <= 6'h00;
            scl_oe_r <= 1'b0;
          end else begin
            cnt_r <= cnt_r - 17'h00001;
          end
        end
        SCL_RISE: begin
          // Slow edge or stretching slave holds off the high count, but no longer than rise_done allows
          if (!run) st_r <= SCL_IDLE;
          else if (scl_s_r | rise_done) begin
            st_r <= SCL_HIGH;
            cnt_r <= hi_len;
          end else begin
            rise_cnt_r <= rise_cnt_r + 6'h01;
          end
        end
        SCL_HIGH: begin
          if (cnt_r != 17'h00001) cnt_r <= cnt_r - 17'h00001;
          else if (run) begin
            st_r <= SCL_LOW;
            cnt_r <= lo_len;
            scl_oe_r <= 1'b1;
          end else st_r <= SCL_IDLE;
        end
      endcase
    end
  end

  // Open drain: only ever pulls low
  assign scl_out = 1'b0;
  assign scl_oe = scl_oe_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [16:0] oe_cnt_r, hi_cnt_r, lo_lat_r, hi_lat_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      oe_cnt_r <= 17'h00000;
      hi_cnt_r <= 17'h00000;
      lo_lat_r <= 17'h00000;
      hi_lat_r <= 17'h00000;
    end else begin
      oe_cnt_r <= scl_oe_r ? oe_cnt_r + 17'h00001 : 17'h00000;
      hi_cnt_r <= (st_r == SCL_HIGH) ? hi_cnt_r + 17'h00001 : 17'h00000;
      if (!scl_oe_r) lo_lat_r <= lo_len;
      if (st_r == SCL_RISE) hi_lat_r <= hi_len;
    end
  end

  property p_role_clear;
    @(posedge sys_clk) disable iff (rst)
      (role_is_master && (stop_generated_i || arb_lost_i) && !master_start_i)
      |=> !role_is_master;
  endproperty
  a_role_clear: assert property (p_role_clear)
    else $error("master flag not cleared");

  property p_role_off;
    @(posedge sys_clk) disable iff (rst) !en |=> !role_is_master;
  endproperty
  a_role_off: assert property (p_role_off)
    else $error("master flag set while disabled");

  property p_busy;
    @(posedge sys_clk) disable iff (rst)
      (!scl_s_r || !sda_s_r) |=> line_busy_flag;
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy flag missing while line low");

  property p_dir;
    @(posedge sys_clk) disable iff (rst)
      (en && addr_dir_valid_i) |=> (dir_r == $past(addr_dir_tx_i));
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction flag wrong");

  property p_bcast_clr;
    @(posedge sys_clk) disable iff (rst)
      (slave_clr && !bcast_hit_i) |=> !bcast_r;
  endproperty
  a_bcast_clr: assert property (p_bcast_clr)
    else $error("broadcast flag not cleared");

  property p_defadr;
    @(posedge sys_clk) disable iff (rst)
      (defadr_r && !$past(defadr_r)) |-> $past(ctrl_r[CTL_ARP]);
  endproperty
  a_defadr: assert property (p_defadr)
    else $error("default address flag without resolution");

  property p_host;
    @(posedge sys_clk) disable iff (rst)
      (en && host_header_hit_i && !role_is_master && ctrl_r[CTL_ARP]
       && ctrl_r[CTL_HOSTSEL]) |=> host_r;
  endproperty
  a_host: assert property (p_host)
    else $error("host header flag not set");

  property p_second;
    @(posedge sys_clk) disable iff (rst)
      (en && own_addr_hit_i && !role_is_master)
      |=> (second_r == $past(own_addr_second_i));
  endproperty
  a_second: assert property (p_second)
    else $error("second address flag wrong");

  property p_chk;
    @(posedge sys_clk) disable iff (rst)
      ctrl_r[CTL_CHKEN] |=> (status_two[CHK_MSB:CHK_LSB] == $past(checksum_i));
  endproperty
  a_chk: assert property (p_chk)
    else $error("checksum field stale");

  property p_low_len;
    @(posedge sys_clk) disable iff (rst)
      ($fell(scl_oe_r) && st_r == SCL_RISE) |-> (oe_cnt_r == lo_lat_r);
  endproperty
  a_low_len: assert property (p_low_len)
    else $error("SCL low phase length wrong");

  property p_high_len;
    @(posedge sys_clk) disable iff (rst)
      ($past(st_r) == SCL_HIGH && st_r != SCL_HIGH) |-> (hi_cnt_r == hi_lat_r);
  endproperty
  a_high_len: assert property (p_high_len)
    else $error("SCL high phase length wrong");

  property p_std_even;
    @(posedge sys_clk) disable iff (rst)
      !clk_ctrl_r[SPEED_BIT] |-> (lo_len == hi_len);
  endproperty
  a_std_even: assert property (p_std_even)
    else $error("standard mode phases unequal");

  property p_rise_wait;
    @(posedge sys_clk) disable iff (rst)
      (st_r == SCL_RISE && run && !scl_s_r && !rise_done) |=> st_r == SCL_RISE;
  endproperty
  a_rise_wait: assert property (p_rise_wait)
    else $error("high phase started too early");

  // Rise limit elapsed must end the wait even with SCL still held low
  property p_rise_bound;
    @(posedge sys_clk) disable iff (rst)
      (st_r == SCL_RISE && run && rise_done) |=> (st_r == SCL_HIGH);
  endproperty
  a_rise_bound: assert property (p_rise_bound)
    else $error("rise limit did not end the wait");

  property p_reset_vals;
    @(posedge sys_clk) disable iff (rst)
      $past(rst) |-> (rise_r == RST_RISE_TIME && clk_ctrl_r == RST_CLK_CTRL
        && status_two == 16'h0000);
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("reset values wrong");

endmodule : i2cst_top
`default_nettype wire
